// ### sim/tb_bfps_sequencer.sv
//----------------------------------------------------------------------------
// Purpose: Self-checking bench for the buck fault-protection sequencer
// Assumes: TICK_CYCLES shortened to 4 clocks; tick phase free running
// Notes:   Delay checks allow a few ticks of slack for sync and tick phase
//----------------------------------------------------------------------------
`timescale 1ns/10ps
module tb_bfps_sequencer;

    //------------------------------------------------------------------------
    // Timing derived from the shortened tick
    //------------------------------------------------------------------------
    localparam int TC = 4;
    localparam int SLACK = 3 * TC;
    localparam int UV_CYC = bfps_pkg::UV_DELAY_TICKS * TC;
    localparam int ARM_CYC = bfps_pkg::UV_ARM_TICKS * TC;
    localparam int HIC_CYC = bfps_pkg::HIC_DELAY_MULT
        * ((1 << bfps_pkg::HIC_EXP_MIN) + bfps_pkg::HIC_BASE) * TC;
    localparam int HIC1_CYC = bfps_pkg::HIC_DELAY_MULT
        * ((1 << (bfps_pkg::HIC_EXP_MIN + 1)) + bfps_pkg::HIC_BASE) * TC;

    typedef struct {
        logic [1:0] code;
        int ticks;
    } bfps_row_t;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] pins = 8'h00;
    logic [1:0] soft_start_sel = 2'h0;
    logic high_side_en;
    logic low_side_en;
    logic soft_start_ramp;
    logic fault_latched;
    logic [3:0] outs;
    int n_fail = 0;
    int total_checks = 0;
    // Soft-start length per code, in 4 us ticks
    bfps_row_t rows [4] = '{'{2'h0, 16'h00AF}, '{2'h1, 16'h015E},
                            '{2'h2, 16'h02BC}, '{2'h3, 16'h0578}};

    assign outs = {fault_latched, soft_start_ramp, low_side_en, high_side_en};

    always #5 clk = ~clk;

    bfps_sequencer #(.TICK_CYCLES(TC)) dut (
        .clk(clk),
        .reset(reset),
        .overcurrent_protect(pins[bfps_pkg::IN_OCP]),
        .undervoltage_protect(pins[bfps_pkg::IN_UV]),
        .overvoltage_protect(pins[bfps_pkg::IN_OV]),
        .redundant_overvoltage_sense(pins[bfps_pkg::IN_ROV]),
        .supply_lockout(pins[bfps_pkg::IN_LOCK]),
        .thermal_hot(pins[bfps_pkg::IN_HOT]),
        .pwm_set(pins[bfps_pkg::IN_PWM]),
        .on_time_done(pins[bfps_pkg::IN_ONDONE]),
        .soft_start_sel(soft_start_sel),
        .high_side_en(high_side_en),
        .low_side_en(low_side_en),
        .soft_start_ramp(soft_start_ramp),
        .fault_latched(fault_latched)
    );

    //------------------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic expect_bit(logic got, logic exp, string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask

    task automatic drive(int k, logic v);
        @(posedge clk);
        pins[k] <= v;
    endtask

    task automatic idle(int c);
        repeat (c) @(negedge clk);
    endtask

    // Bounded wait; a miss ends the run since later steps would cascade
    task automatic wait_out(int k, logic v, int maxc, output int n);
        n = 0;
        @(negedge clk);
        while (outs[k] !== v) begin
            n++;
            if (n > maxc) begin
                n_fail++;
                $display("unexpected at %0t: output %0d stuck", $time, k);
                conclude();
            end
            @(negedge clk);
        end
    endtask

    // Reset, release and run through soft-start; n is the ramp length
    task automatic start(logic [1:0] code, output int n);
        @(posedge clk);
        reset <= 1'b1;
        pins <= 8'h00;
        soft_start_sel <= code;
        repeat (12) @(posedge clk);
        @(negedge clk);
        expect_bit(|outs, 1'b0, "outputs in reset");
        @(posedge clk);
        reset <= 1'b0;
        wait_out(2, 1'b1, 5, n);
        wait_out(2, 1'b0, (16'h0578 * TC) + SLACK, n);
    endtask

    //------------------------------------------------------------------------
    // Sequence
    //------------------------------------------------------------------------
    initial begin
        int n;
        int k;
        for (int i = 0; i < 4; i++) begin
            start(rows[i].code, n);
            expect_bit((n >= rows[i].ticks * TC - SLACK) && (n <= rows[i].ticks * TC + SLACK),
                       1'b1, "soft-start length");
        end

        // Switching: turn-on, on-phase overcurrent ignored, off-phase blocking
        start(2'h0, n);
        drive(bfps_pkg::IN_PWM, 1'b1);
        wait_out(0, 1'b1, 10, n);
        expect_bit(low_side_en, 1'b0, "low side in on phase");
        drive(bfps_pkg::IN_PWM, 1'b0);
        drive(bfps_pkg::IN_OCP, 1'b1);
        idle(8);
        expect_bit(high_side_en, 1'b1, "high side during on phase");
        drive(bfps_pkg::IN_ONDONE, 1'b1);
        wait_out(0, 1'b0, 10, n);
        expect_bit(low_side_en, 1'b1, "low side in off phase");
        drive(bfps_pkg::IN_ONDONE, 1'b0);
        drive(bfps_pkg::IN_PWM, 1'b1);
        idle(12);
        expect_bit(high_side_en, 1'b0, "turn-on under overcurrent");
        drive(bfps_pkg::IN_OCP, 1'b0);
        wait_out(0, 1'b1, 10, n);

        // Undervoltage: arming delay, latch-off delay, hiccup and repeat
        start(2'h0, n);
        drive(bfps_pkg::IN_UV, 1'b1);
        idle(ARM_CYC - 25 * TC);
        expect_bit(low_side_en, 1'b1, "drive before arming");
        drive(bfps_pkg::IN_UV, 1'b0);
        idle(50 * TC);
        drive(bfps_pkg::IN_UV, 1'b1);
        idle(UV_CYC - SLACK);
        expect_bit(low_side_en, 1'b1, "drive before delay ends");
        wait_out(1, 1'b0, 2 * SLACK, n);
        expect_bit(high_side_en, 1'b0, "high side after latch-off");
        // New code is taken at the restart and sets the second hiccup length
        @(posedge clk);
        soft_start_sel <= 2'h1;
        wait_out(2, 1'b1, HIC_CYC + SLACK, n);
        expect_bit(n >= HIC_CYC - SLACK, 1'b1, "hiccup delay too short");
        wait_out(2, 1'b0, rows[1].ticks * TC + SLACK, n);
        expect_bit(n >= rows[1].ticks * TC - SLACK, 1'b1, "restart ramp code");
        wait_out(1, 1'b0, ARM_CYC + UV_CYC + 2 * SLACK, n);
        wait_out(2, 1'b1, HIC1_CYC + SLACK, n);
        expect_bit(n >= HIC1_CYC - SLACK, 1'b1, "repeat hiccup too short");
        drive(bfps_pkg::IN_UV, 1'b0);

        // Overvoltage on feedback and on the redundant sense
        for (int j = 0; j < 2; j++) begin
            k = (j == 0) ? bfps_pkg::IN_OV : bfps_pkg::IN_ROV;
            start(2'h0, n);
            drive(bfps_pkg::IN_PWM, 1'b1);
            wait_out(0, 1'b1, 10, n);
            drive(k, 1'b1);
            wait_out(0, 1'b0, 5, n);
            expect_bit(low_side_en, 1'b1, "low side discharging");
            drive(k, 1'b0);
            idle(20);
            expect_bit(high_side_en, 1'b0, "high side latched off");
            drive(bfps_pkg::IN_UV, 1'b1);
            idle(UV_CYC - SLACK);
            expect_bit(low_side_en, 1'b1, "low side held");
            wait_out(1, 1'b0, 2 * SLACK, n);
            expect_bit(fault_latched, 1'b1, "fault latch");
            idle(20);
            expect_bit(|outs[2:0], 1'b0, "drives after latch");
        end

        // Supply lockout and thermal shutdown, both self-clearing
        for (int j = 0; j < 2; j++) begin
            k = (j == 0) ? bfps_pkg::IN_LOCK : bfps_pkg::IN_HOT;
            start(2'h0, n);
            drive(bfps_pkg::IN_PWM, 1'b1);
            wait_out(0, 1'b1, 10, n);
            drive(k, 1'b1);
            wait_out(0, 1'b0, 5, n);
            idle(5);
            expect_bit(low_side_en, 1'b0, "low side while stopped");
            drive(bfps_pkg::IN_PWM, 1'b0);
            drive(k, 1'b0);
            wait_out(2, 1'b1, 10, n);
        end
        conclude();
    end

endmodule

// ### src/bfps_pkg.sv
//----------------------------------------------------------------------------
// Purpose: Shared constants and types for the buck fault-protection sequencer
// Assumes: 100 MHz clk, 4 us protection timebase
// Notes:   All delays are counted in timebase ticks except the tick itself
//----------------------------------------------------------------------------
package bfps_pkg;

    //------------------------------------------------------------------------
    // Clock and timebase
    //------------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 4000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_US = TICK_NS / 1000;

    //------------------------------------------------------------------------
    // Protection delays, printed units then tick counts
    //------------------------------------------------------------------------
    localparam int UV_DELAY_US = 1000;
    localparam int UV_DELAY_TICKS = UV_DELAY_US / TICK_US;
    localparam int UV_ARM_US = 1500;
    localparam int UV_ARM_TICKS = UV_ARM_US / TICK_US;
    localparam int SS_BASE_US = 700;
    localparam int SS_BASE_TICKS = SS_BASE_US / TICK_US;
    localparam int HIC_BASE = 257;
    localparam int HIC_EXP_MIN = 8;
    localparam int HIC_DELAY_MULT = 7;

    //------------------------------------------------------------------------
    // Synchronised input vector layout
    //------------------------------------------------------------------------
    localparam int SYNC_W = 10;
    localparam int IN_OCP = 0;
    localparam int IN_UV = 1;
    localparam int IN_OV = 2;
    localparam int IN_ROV = 3;
    localparam int IN_LOCK = 4;
    localparam int IN_HOT = 5;
    localparam int IN_PWM = 6;
    localparam int IN_ONDONE = 7;
    localparam int IN_SEL = 8;

    localparam int CNT_W = 16;
    localparam int UVC_W = 8;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_SOFT,
        ST_RUN,
        ST_HICCUP,
        ST_OV_DISCH,
        ST_LATCH,
        ST_STOP
    } bfps_state_t;

endpackage

// ### src/bfps_sequencer.sv
//----------------------------------------------------------------------------
// Purpose: Fault-protection sequencer and gate-drive enable control
// Assumes: Comparator results arrive asynchronously and are synchronised here
// Notes:   Inputs pass two flip-flops; drives are registered
// Functional notes
// - Overcurrent in off state blocks high-side turn-on
// - Overcurrent compared only during the off state
// - Sustained overcurrent undervoltage leads to repeating hiccup
// - Hiccup wait is 2^n plus 257 ticks
// - Hiccup delay equals seven hiccup wait intervals
// - Undervoltage input starts the undervoltage delay counter
// - Undervoltage held 1 ms latches both drives off
// - After undervoltage latch-off wait hiccup delay, restart
// - Undervoltage armed 1.5 ms after soft-start completes
// - Overvoltage latches high-side off, low-side on
// - Low-side held until undervoltage 1 ms, then off
// - Redundant overvoltage sense acts like overvoltage
// - Supply lockout stops drives, clears itself on recovery
// - Thermal shutdown stops drives, clears itself when cool
// - Pulse-width comparator sets high-side turn-on, gated by overcurrent
// - Four soft-start codes also pick hiccup exponent
//----------------------------------------------------------------------------
`timescale 1ns/10ps
module bfps_sequencer #(
    parameter int TICK_CYCLES = bfps_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Protection comparators, asynchronous
    input wire logic overcurrent_protect,
    input wire logic undervoltage_protect,
    input wire logic overvoltage_protect,
    input wire logic redundant_overvoltage_sense,
    input wire logic supply_lockout,
    input wire logic thermal_hot,
    // Switching control, asynchronous
    input wire logic pwm_set,
    input wire logic on_time_done,
    input wire logic [1:0] soft_start_sel,
    // Gate drives and status
    output logic high_side_en,
    output logic low_side_en,
    output logic soft_start_ramp,
    output logic fault_latched
);
    //------------------------------------------------------------------------
    // State
    //------------------------------------------------------------------------
    typedef struct packed {
        logic [bfps_pkg::SYNC_W-1:0] sync1;
        logic [bfps_pkg::SYNC_W-1:0] sync2;
        bfps_pkg::bfps_state_t state;
        logic on_phase;
        logic armed;
        logic [1:0] ss_sel;
        logic [bfps_pkg::CNT_W-1:0] cnt;
        logic [bfps_pkg::UVC_W-1:0] uv_cnt;
        logic hs;
        logic ls;
    } bfps_main_t;

    bfps_main_t s_r;
    bfps_main_t s_nxt;
    bfps_tick_if tbi ();

    bfps_timebase #(.TICK_CYCLES(TICK_CYCLES)) u_timebase (
        .clk(clk),
        .reset(reset),
        .tb(tbi.src)
    );

    //------------------------------------------------------------------------
    // Decoded synchronised inputs
    //------------------------------------------------------------------------
    logic tick;
    logic ocp_s;
    logic uv_s;
    logic ov_s;
    logic shut_s;
    logic pwm_s;
    logic ondone_s;
    logic switching;
    logic [bfps_pkg::CNT_W-1:0] hic_len;
    logic [bfps_pkg::CNT_W-1:0] ss_len;

    assign tick = tbi.tick;
    assign ocp_s = s_r.sync2[bfps_pkg::IN_OCP];
    assign uv_s = s_r.sync2[bfps_pkg::IN_UV];
    // Either sense path triggers the same discharge
    assign ov_s = s_r.sync2[bfps_pkg::IN_OV] | s_r.sync2[bfps_pkg::IN_ROV];
    assign shut_s = s_r.sync2[bfps_pkg::IN_LOCK] | s_r.sync2[bfps_pkg::IN_HOT];
    assign pwm_s = s_r.sync2[bfps_pkg::IN_PWM];
    assign ondone_s = s_r.sync2[bfps_pkg::IN_ONDONE];
    assign switching = (s_r.state == bfps_pkg::ST_SOFT) || (s_r.state == bfps_pkg::ST_RUN);

    // Seven wait intervals of (2^n + 257) ticks, n = 8 + code
    assign hic_len = bfps_pkg::CNT_W'(bfps_pkg::HIC_DELAY_MULT *
        ((1 << (bfps_pkg::HIC_EXP_MIN + int'(s_r.ss_sel))) + bfps_pkg::HIC_BASE));
    // Ramp time doubles with each code
    assign ss_len = bfps_pkg::CNT_W'(bfps_pkg::SS_BASE_TICKS << s_r.ss_sel);

    //------------------------------------------------------------------------
    // Next-state logic
    //------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = {soft_start_sel, on_time_done, pwm_set, thermal_hot, supply_lockout,
            redundant_overvoltage_sense, overvoltage_protect, undervoltage_protect,
            overcurrent_protect};
        s_nxt.sync2 = s_r.sync1;

        // Cycle-by-cycle switching; current looked at only while off
        if (switching) begin
            if (s_r.on_phase) begin
                if (ondone_s) begin
                    s_nxt.on_phase = 1'b0;
                end
            end else if (pwm_s && !ocp_s) begin
                s_nxt.on_phase = 1'b1;
            end
        end else begin
            s_nxt.on_phase = 1'b0;
        end

        case (s_r.state)
            bfps_pkg::ST_INIT: begin
                // Code is sampled once per start so a restart picks up changes
                s_nxt.ss_sel = s_r.sync2[bfps_pkg::IN_SEL +: 2];
                s_nxt.cnt = '0;
                s_nxt.uv_cnt = '0;
                s_nxt.armed = 1'b0;
                s_nxt.state = bfps_pkg::ST_SOFT;
            end
            bfps_pkg::ST_SOFT: begin
                if (tick) begin
                    if (s_r.cnt == ss_len - 16'h0001) begin
                        s_nxt.cnt = '0;
                        s_nxt.state = bfps_pkg::ST_RUN;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
            end
            bfps_pkg::ST_RUN: begin
                // Undervoltage stays ignored until the arming delay has passed
                if (!s_r.armed) begin
                    if (tick) begin
                        if (s_r.cnt == bfps_pkg::CNT_W'(bfps_pkg::UV_ARM_TICKS - 1)) begin
                            s_nxt.armed = 1'b1;
                            s_nxt.cnt = '0;
                        end else begin
                            s_nxt.cnt = s_r.cnt + 16'h0001;
                        end
                    end
                end else if (uv_s) begin
                    if (tick) begin
                        if (s_r.uv_cnt == bfps_pkg::UVC_W'(bfps_pkg::UV_DELAY_TICKS - 1)) begin
                            s_nxt.uv_cnt = '0;
                            s_nxt.cnt = '0;
                            s_nxt.state = bfps_pkg::ST_HICCUP;
                        end else begin
                            s_nxt.uv_cnt = s_r.uv_cnt + 8'h01;
                        end
                    end
                end else begin
                    s_nxt.uv_cnt = '0;
                end
            end
            bfps_pkg::ST_HICCUP: begin
                if (tick) begin
                    if (s_r.cnt == hic_len - 16'h0001) begin
                        s_nxt.state = bfps_pkg::ST_INIT;
                    end else begin
                        s_nxt.cnt = s_r.cnt + 16'h0001;
                    end
                end
            end
            bfps_pkg::ST_OV_DISCH: begin
                // Discharge continues until the output has sat low for the delay
                if (uv_s) begin
                    if (tick) begin
                        if (s_r.uv_cnt == bfps_pkg::UVC_W'(bfps_pkg::UV_DELAY_TICKS - 1)) begin
                            s_nxt.state = bfps_pkg::ST_LATCH;
                        end else begin
                            s_nxt.uv_cnt = s_r.uv_cnt + 8'h01;
                        end
                    end
                end else begin
                    s_nxt.uv_cnt = '0;
                end
            end
            bfps_pkg::ST_LATCH: begin
                // Only a power-on reset leaves the latched-off state
                s_nxt.state = bfps_pkg::ST_LATCH;
            end
            bfps_pkg::ST_STOP: begin
                if (!shut_s) begin
                    s_nxt.state = bfps_pkg::ST_INIT;
                end
            end
            default: begin
                s_nxt.state = bfps_pkg::ST_INIT;
            end
        endcase

        // Overvoltage takes over any switching state
        if (switching && ov_s) begin
            s_nxt.uv_cnt = '0;
            s_nxt.state = bfps_pkg::ST_OV_DISCH;
        end

        // Lockout and thermal win over everything but the overvoltage latch
        if (shut_s && (s_r.state != bfps_pkg::ST_LATCH)) begin
            s_nxt.state = bfps_pkg::ST_STOP;
        end

        // Drives follow the next state so faults cut them in one cycle
        s_nxt.hs = 1'b0;
        s_nxt.ls = 1'b0;
        if ((s_nxt.state == bfps_pkg::ST_SOFT) || (s_nxt.state == bfps_pkg::ST_RUN)) begin
            s_nxt.hs = s_nxt.on_phase;
            s_nxt.ls = !s_nxt.on_phase;
        end else if (s_nxt.state == bfps_pkg::ST_OV_DISCH) begin
            s_nxt.ls = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
            // Synchronisers keep sampling so the start-up code is valid at release
            s_r.sync1 <= s_nxt.sync1;
            s_r.sync2 <= s_nxt.sync2;
        end else begin
            s_r <= s_nxt;
        end
    end

    //------------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------------
    assign high_side_en = s_r.hs;
    assign low_side_en = s_r.ls;
    assign soft_start_ramp = (s_r.state == bfps_pkg::ST_SOFT);
    assign fault_latched = (s_r.state == bfps_pkg::ST_LATCH);

    //------------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    a_ocp_blocks_on: assert property (
        (switching && !s_r.on_phase && ocp_s) |=> !high_side_en)
        else $error("high side turned on during overcurrent");

    a_hs_needs_set: assert property (
        $rose(high_side_en) |-> $past(pwm_s) && !$past(ocp_s))
        else $error("high side on without set or with overcurrent");

    a_ocp_ignored_on: assert property (
        (switching && s_r.on_phase && !ondone_s && !ov_s && !shut_s && ocp_s
            && s_r.state == bfps_pkg::ST_RUN && !(uv_s && s_r.armed))
        |=> high_side_en)
        else $error("overcurrent acted during on state");

    a_shut_drives_off: assert property (
        shut_s |=> !high_side_en && !low_side_en)
        else $error("drives active during lockout or thermal stop");

    a_stop_restart: assert property (
        (s_r.state == bfps_pkg::ST_STOP && !shut_s) |=> s_r.state == bfps_pkg::ST_INIT
            ##1 (s_r.state == bfps_pkg::ST_SOFT || $past(shut_s)))
        else $error("no soft-start restart after lockout cleared");

    a_uv_arm_delay: assert property (
        $rose(s_r.armed) |-> $past(tick) && $past(s_r.state) == bfps_pkg::ST_RUN
            && $past(s_r.cnt) == bfps_pkg::CNT_W'(bfps_pkg::UV_ARM_TICKS - 1))
        else $error("undervoltage armed before its delay");

    a_uv_to_hiccup: assert property (
        (s_r.state == bfps_pkg::ST_RUN && s_r.armed && uv_s && tick && !ov_s && !shut_s
            && s_r.uv_cnt == bfps_pkg::UVC_W'(bfps_pkg::UV_DELAY_TICKS - 1))
        |=> s_r.state == bfps_pkg::ST_HICCUP && !high_side_en && !low_side_en)
        else $error("undervoltage delay did not latch off");

    a_hiccup_end: assert property (
        (s_r.state == bfps_pkg::ST_HICCUP && tick && !shut_s && s_r.cnt == hic_len - 16'h0001)
        |=> s_r.state == bfps_pkg::ST_INIT)
        else $error("hiccup did not end at its delay");

    a_hiccup_bound: assert property (
        (s_r.state == bfps_pkg::ST_HICCUP) |-> s_r.cnt < hic_len)
        else $error("hiccup count beyond delay");

    a_ov_discharge: assert property (
        (switching && ov_s && !shut_s) |=> low_side_en && !high_side_en
            && s_r.state == bfps_pkg::ST_OV_DISCH)
        else $error("overvoltage did not force low side on");

    a_latch_sticks: assert property (
        (s_r.state == bfps_pkg::ST_LATCH) |=> s_r.state == bfps_pkg::ST_LATCH
            && !high_side_en && !low_side_en)
        else $error("latched off state left or drives active");

    a_drives_exclusive: assert property (
        !(high_side_en && low_side_en))
        else $error("both drives enabled");

    c_hiccup: cover property (s_r.state == bfps_pkg::ST_HICCUP ##1
        s_r.state == bfps_pkg::ST_HICCUP);
    c_ov_latch: cover property (s_r.state == bfps_pkg::ST_OV_DISCH ##1
        s_r.state == bfps_pkg::ST_LATCH);
    c_run_switch: cover property ((s_r.state == bfps_pkg::ST_RUN) && $rose(high_side_en));
    c_stop: cover property (s_r.state == bfps_pkg::ST_STOP);
endmodule

// ### src/bfps_tick_if.sv
//----------------------------------------------------------------------------
// Purpose: Carries the protection timebase tick between modules
// Assumes: Single clock domain
// Notes:   tick is a one-cycle pulse
//----------------------------------------------------------------------------
`timescale 1ns/10ps
interface bfps_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface

// ### src/bfps_timebase.sv
//----------------------------------------------------------------------------
// Purpose: Divides clk into the periodic protection tick
// Assumes: TICK_CYCLES >= 2
// Notes:   Tick is registered, one cycle wide
//----------------------------------------------------------------------------
`timescale 1ns/10ps
module bfps_timebase #(
    parameter int TICK_CYCLES = bfps_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Tick out
    bfps_tick_if.src tb
);
    typedef struct packed {
        logic [bfps_pkg::CNT_W-1:0] cnt;
        logic tick;
    } bfps_tb_t;

    bfps_tb_t s_r;
    bfps_tb_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == bfps_pkg::CNT_W'(TICK_CYCLES - 1)) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tb.tick = s_r.tick;

    a_tick_single: assert property (@(posedge clk) disable iff (reset)
        s_r.tick |=> !s_r.tick) else $error("tick longer than one cycle");
endmodule
